/* inc/bla_pkg.sv */
// constants and types shared by the byte logic and arithmetic datapath
`default_nettype none

package bla_pkg;

  // ==========================================================
  // widths and sizes
  localparam int DATA_W   = 8;
  localparam int REG_CNT  = 16;
  localparam int SEL_W    = 4;
  localparam int BYTE_MAX = 255;
  localparam int BYTE_WRAP = 256;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic              FLAG_RST = 1'b0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int CYCLES_PER_INSTR = 2;

  // ==========================================================
  // port ids used by a port-attached multiplier
  localparam logic [7:0] MULT_PORT_LO = 8'h00;
  localparam logic [7:0] MULT_PORT_HI = 8'h01;

  // ==========================================================
  // operations
  typedef enum logic [2:0] {
    OP_LOAD  = 3'h0,
    OP_AND   = 3'h1,
    OP_OR    = 3'h2,
    OP_XOR   = 3'h3,
    OP_ADD   = 3'h4,
    OP_ADD_WITH_CARRY_IN = 3'h5,
    OP_SUB   = 3'h6,
    OP_SUBTRACT_WITH_BORROW_IN = 3'h7
  } bla_op_t;

  // ==========================================================
  // instruction phase, gray along fetch -> execute
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_EXEC = 2'h1
  } bla_phase_t;

endpackage

`default_nettype wire

/* logic/bla_regfile.sv */
// sixteen by eight general purpose register file
`default_nettype none
`timescale 1ns/1ns

module bla_regfile (
  // clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  // write port
  input  wire logic                       i_wr_en,
  input  wire logic [bla_pkg::SEL_W-1:0]  i_wr_sel,
  input  wire logic [bla_pkg::DATA_W-1:0] i_wr_data,
  // read ports
  input  wire logic [bla_pkg::SEL_W-1:0]  i_rd_a_sel,
  input  wire logic [bla_pkg::SEL_W-1:0]  i_rd_b_sel,
  input  wire logic [bla_pkg::SEL_W-1:0]  i_rd_c_sel,
  output logic      [bla_pkg::DATA_W-1:0] o_rd_a,
  output logic      [bla_pkg::DATA_W-1:0] o_rd_b,
  output logic      [bla_pkg::DATA_W-1:0] o_rd_c
);

  typedef struct packed {
    logic [bla_pkg::REG_CNT-1:0][bla_pkg::DATA_W-1:0] mem;
  } bla_rf_st_t;

  bla_rf_st_t st_r;
  bla_rf_st_t st_nxt;
  logic [bla_pkg::REG_CNT-1:0][bla_pkg::DATA_W-1:0] mem_nxt;

  // ==========================================================
  // per entry write decode
  genvar gi;
  generate
    for (gi = 0; gi < bla_pkg::REG_CNT; gi++) begin : g_entry
      assign mem_nxt[gi] =
        (i_wr_en && (int'(i_wr_sel) == gi)) ?
        i_wr_data : st_r.mem[gi];
    end
  endgenerate

  always_comb begin
    st_nxt     = st_r;
    st_nxt.mem = mem_nxt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r.mem <= {bla_pkg::REG_CNT{bla_pkg::REG_RST}};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_a = st_r.mem[i_rd_a_sel];
  assign o_rd_b = st_r.mem[i_rd_b_sel];
  assign o_rd_c = st_r.mem[i_rd_c_sel];

endmodule // bla_regfile

`default_nettype wire

/* logic/bla_alu.sv */
// byte logic and add/subtract datapath with flags and register file
`default_nettype none
`timescale 1ns/1ns

// Overview of operation
// - xor of a register with itself writes zero and sets zero flag.
// - load of 00 clears the register; load never touches flags.
// - or forces mask-one bits high, keeps mask-zero bits.
// - and forces mask-zero bits low, keeps mask-one bits.
// - adds take a register plus a register or literal byte.
// - add sets carry when sum exceeds 255, stores low byte.
// - add sets zero when sum is 0 or 256.
// - add with carry in adds one more when carry is set.
// - subtract carry is borrow, set when difference below zero.
// - subtract sets zero when difference is 0 or -256.
// - subtract with borrow in takes one more when carry set.
// - logic operations clear carry, zero flag marks zero result.
// - every instruction takes two clock cycles.
// - any of 16 registers may be either operand.
module bla_alu (
  // clock, reset, enable
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  // instruction from decoder
  input  wire logic                       i_op_valid,
  input  wire bla_pkg::bla_op_t           i_op,
  input  wire logic [bla_pkg::SEL_W-1:0]  i_dst_sel,
  input  wire logic [bla_pkg::SEL_W-1:0]  i_src_sel,
  input  wire logic                       i_use_literal,
  input  wire logic [bla_pkg::DATA_W-1:0] i_literal,
  // register observation
  input  wire logic [bla_pkg::SEL_W-1:0]  i_peek_sel,
  // status and results
  output logic                            o_busy,
  output logic                            o_done,
  output logic                            o_zero,
  output logic                            o_carry,
  output logic      [bla_pkg::DATA_W-1:0] o_wr_data,
  output logic      [bla_pkg::DATA_W-1:0] o_peek_data
);

  typedef struct packed {
    bla_pkg::bla_phase_t         phase;
    bla_pkg::bla_op_t            op;
    logic [bla_pkg::SEL_W-1:0]   dst;
    logic [bla_pkg::DATA_W-1:0]  opa;
    logic [bla_pkg::DATA_W-1:0]  opb;
    logic                        zero;
    logic                        carry;
    logic                        done;
    logic                        busy;
    logic [bla_pkg::DATA_W-1:0]  wr_data;
    logic [bla_pkg::DATA_W-1:0]  peek;
  } bla_alu_st_t;

  bla_alu_st_t st_r;
  bla_alu_st_t st_nxt;
  logic [bla_pkg::DATA_W-1:0] rd_a;
  logic [bla_pkg::DATA_W-1:0] rd_b;
  logic [bla_pkg::DATA_W-1:0] rd_c;
  logic                       wr_en;
  logic [bla_pkg::DATA_W:0]   sum9;
  logic [bla_pkg::DATA_W:0]   diff9;
  logic                       cin_add;
  logic                       cin_sub;
  logic [bla_pkg::DATA_W-1:0] res;
  logic                       res_c;
  logic                       res_z;

  // ==========================================================
  // register file
  bla_regfile u_regfile (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_wr_en    (wr_en),
    .i_wr_sel   (st_r.dst),
    .i_wr_data  (res),
    .i_rd_a_sel (i_dst_sel),
    .i_rd_b_sel (i_src_sel),
    .i_rd_c_sel (i_peek_sel),
    .o_rd_a     (rd_a),
    .o_rd_b     (rd_b),
    .o_rd_c     (rd_c)
  );

  // ==========================================================
  // arithmetic core
  // carry chained add
  assign cin_add = st_r.carry &&
                   (st_r.op == bla_pkg::OP_ADD_WITH_CARRY_IN);
  assign cin_sub = st_r.carry &&
                   (st_r.op == bla_pkg::OP_SUBTRACT_WITH_BORROW_IN);
  assign sum9  = {1'b0, st_r.opa} + {1'b0, st_r.opb} +
                 {8'h00, cin_add};
  // nine bit difference, top bit is borrow
  assign diff9 = {1'b0, st_r.opa} - {1'b0, st_r.opb} -
                 {8'h00, cin_sub};

  always_comb begin
    res   = st_r.opb;
    res_c = st_r.carry;
    res_z = st_r.zero;
    unique case (st_r.op)
      bla_pkg::OP_LOAD: begin
        res = st_r.opb;
      end
      bla_pkg::OP_AND: begin
        res   = st_r.opa & st_r.opb;
        res_c = 1'b0;
        res_z = (res == bla_pkg::ZERO_BYTE);
      end
      bla_pkg::OP_OR: begin
        res   = st_r.opa | st_r.opb;
        res_c = 1'b0;
        res_z = (res == bla_pkg::ZERO_BYTE);
      end
      bla_pkg::OP_XOR: begin
        res   = st_r.opa ^ st_r.opb;
        res_c = 1'b0;
        res_z = (res == bla_pkg::ZERO_BYTE);
      end
      bla_pkg::OP_ADD,
      bla_pkg::OP_ADD_WITH_CARRY_IN: begin
        res   = sum9[bla_pkg::DATA_W-1:0];
        res_c = sum9[bla_pkg::DATA_W];
        res_z = (res == bla_pkg::ZERO_BYTE);
      end
      bla_pkg::OP_SUB,
      bla_pkg::OP_SUBTRACT_WITH_BORROW_IN: begin
        res   = diff9[bla_pkg::DATA_W-1:0];
        res_c = diff9[bla_pkg::DATA_W];
        res_z = (res == bla_pkg::ZERO_BYTE);
      end
    endcase
  end

  // ==========================================================
  // instruction sequencing
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    st_nxt.peek = rd_c;
    wr_en       = 1'b0;
    unique case (st_r.phase)
      bla_pkg::PH_IDLE: begin
        if (i_op_valid) begin
          st_nxt.phase = bla_pkg::PH_EXEC;
          st_nxt.busy  = 1'b1;
          st_nxt.op    = i_op;
          st_nxt.dst   = i_dst_sel;
          st_nxt.opa   = rd_a;
          st_nxt.opb   = i_use_literal ? i_literal : rd_b;
        end
      end
      bla_pkg::PH_EXEC: begin
        wr_en          = 1'b1;
        st_nxt.wr_data = res;
        st_nxt.carry   = res_c;
        st_nxt.zero    = res_z;
        st_nxt.done    = 1'b1;
        st_nxt.busy    = 1'b0;
        st_nxt.phase   = bla_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r.phase   <= bla_pkg::PH_IDLE;
      st_r.op      <= bla_pkg::OP_LOAD;
      st_r.dst     <= '0;
      st_r.opa     <= bla_pkg::REG_RST;
      st_r.opb     <= bla_pkg::REG_RST;
      st_r.zero    <= bla_pkg::FLAG_RST;
      st_r.carry   <= bla_pkg::FLAG_RST;
      st_r.done    <= 1'b0;
      st_r.busy    <= 1'b0;
      st_r.wr_data <= bla_pkg::REG_RST;
      st_r.peek    <= bla_pkg::REG_RST;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_busy      = st_r.busy;
  assign o_done      = st_r.done;
  assign o_zero      = st_r.zero;
  assign o_carry     = st_r.carry;
  assign o_wr_data   = st_r.wr_data;
  assign o_peek_data = st_r.peek;

  // ==========================================================
  // checks
  logic ex_go;
  logic acc_go;
  assign ex_go  = (st_r.phase == bla_pkg::PH_EXEC) && i_ce;
  assign acc_go = (st_r.phase == bla_pkg::PH_IDLE) && i_ce &&
                  i_op_valid;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_xor_self;
    ex_go && (st_r.op == bla_pkg::OP_XOR) && (st_r.opa == st_r.opb)
      |=> (o_wr_data == bla_pkg::ZERO_BYTE) && o_zero;
  endproperty
  a_xor_self: assert property (p_xor_self)
    else $error("xor with itself did not clear and set zero");

  property p_load_flags;
    ex_go && (st_r.op == bla_pkg::OP_LOAD)
      |=> (o_zero == $past(o_zero)) && (o_carry == $past(o_carry)) &&
          (o_wr_data == st_r.opb);
  endproperty
  a_load_flags: assert property (p_load_flags)
    else $error("load changed a flag or stored wrong value");

  property p_or_mask;
    ex_go && (st_r.op == bla_pkg::OP_OR)
      |=> ((o_wr_data & st_r.opb) == st_r.opb) &&
          ((o_wr_data & ~st_r.opb) == (st_r.opa & ~st_r.opb));
  endproperty
  a_or_mask: assert property (p_or_mask)
    else $error("or did not set mask bits or keep others");

  property p_and_mask;
    ex_go && (st_r.op == bla_pkg::OP_AND)
      |=> ((o_wr_data & ~st_r.opb) == bla_pkg::ZERO_BYTE) &&
          ((o_wr_data & st_r.opb) == (st_r.opa & st_r.opb));
  endproperty
  a_and_mask: assert property (p_and_mask)
    else $error("and did not clear mask bits or keep others");

  property p_opb_select;
    acc_go |=> (st_r.opb == ($past(i_use_literal) ?
                             $past(i_literal) : $past(rd_b)));
  endproperty
  a_opb_select: assert property (p_opb_select)
    else $error("second operand not taken from literal or register");

  property p_add_carry;
    ex_go && (st_r.op == bla_pkg::OP_ADD)
      |=> (o_carry == ((int'(st_r.opa) + int'(st_r.opb)) >
                       bla_pkg::BYTE_MAX)) &&
          (o_wr_data == 8'(int'(st_r.opa) + int'(st_r.opb)));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry or low byte wrong");

  property p_add_zero;
    ex_go && ((st_r.op == bla_pkg::OP_ADD) ||
              (st_r.op == bla_pkg::OP_ADD_WITH_CARRY_IN))
      |=> o_zero == (((int'(st_r.opa) + int'(st_r.opb) +
                       int'($past(o_carry) && (st_r.op ==
                        bla_pkg::OP_ADD_WITH_CARRY_IN)))
                      % bla_pkg::BYTE_WRAP) == 0);
  endproperty
  a_add_zero: assert property (p_add_zero)
    else $error("add zero flag wrong");

  property p_addc_chain;
    ex_go && (st_r.op == bla_pkg::OP_ADD_WITH_CARRY_IN) && st_r.carry
      |=> o_carry == ((int'(st_r.opa) + int'(st_r.opb) + 1) >
                      bla_pkg::BYTE_MAX);
  endproperty
  a_addc_chain: assert property (p_addc_chain)
    else $error("carry in not added");

  property p_sub_borrow;
    ex_go && (st_r.op == bla_pkg::OP_SUB)
      |=> (o_carry == (st_r.opa < st_r.opb)) &&
          (o_zero == (st_r.opa == st_r.opb));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract borrow or zero wrong");

  property p_subb_zero;
    ex_go && (st_r.op == bla_pkg::OP_SUBTRACT_WITH_BORROW_IN)
      |=> o_zero == (8'(st_r.opa - st_r.opb -
                        {7'h00, $past(o_carry)}) == bla_pkg::ZERO_BYTE);
  endproperty
  a_subb_zero: assert property (p_subb_zero)
    else $error("borrow subtract zero flag wrong");

  property p_subb_chain;
    ex_go && (st_r.op == bla_pkg::OP_SUBTRACT_WITH_BORROW_IN) &&
      st_r.carry
      |=> o_carry == (int'(st_r.opa) < (int'(st_r.opb) + 1));
  endproperty
  a_subb_chain: assert property (p_subb_chain)
    else $error("borrow in not taken away");

  property p_logic_flags;
    ex_go && ((st_r.op == bla_pkg::OP_AND) ||
              (st_r.op == bla_pkg::OP_OR) ||
              (st_r.op == bla_pkg::OP_XOR))
      |=> !o_carry && (o_zero == (o_wr_data == bla_pkg::ZERO_BYTE));
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic operation flags wrong");

  property p_two_cycles;
    acc_go ##1 i_ce |=> o_done && !o_busy;
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("instruction did not end on second clock");

  property p_opa_select;
    acc_go |=> (st_r.opa == $past(rd_a)) && (st_r.dst == $past(i_dst_sel))
               && o_busy;
  endproperty
  a_opa_select: assert property (p_opa_select)
    else $error("first operand register not captured");

  property p_writeback;
    ex_go |-> wr_en ##1 (o_wr_data == $past(res));
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("result not written back");
endmodule // bla_alu

`default_nettype wire

/* verification/bla_decoder_model.sv */
// instruction decoder stand-in that issues requests to the datapath
`default_nettype none
`timescale 1ns/1ns

module bla_decoder_model (
  // clock
  input  wire logic                       i_ref_clk,
  // instruction to datapath
  output logic                            o_op_valid,
  output bla_pkg::bla_op_t                o_op,
  output logic      [bla_pkg::SEL_W-1:0]  o_dst_sel,
  output logic      [bla_pkg::SEL_W-1:0]  o_src_sel,
  output logic                            o_use_literal,
  output logic      [bla_pkg::DATA_W-1:0] o_literal
);
  // stand-in multiplier on the port bus
  logic [7:0]  mul_a;
  logic [7:0]  mul_b;
  logic [15:0] mul_prod;

  // product ready one clock after operands
  always @(posedge i_ref_clk) mul_prod <= mul_a * mul_b;

  initial begin
    o_op_valid    = 1'b0;
    o_op          = bla_pkg::OP_LOAD;
    o_dst_sel     = 4'h0;
    o_src_sel     = 4'h0;
    o_use_literal = 1'b0;
    o_literal     = 8'h00;
    mul_a         = 8'h00;
    mul_b         = 8'h00;
  end

  // caller is just past an edge; request held for hold edges
  task automatic issue(input bla_pkg::bla_op_t op, input logic [3:0] dst,
                       input logic [3:0] src, input logic use_lit,
                       input logic [7:0] lit, input int hold);
    o_op_valid    = 1'b1;
    o_op          = op;
    o_dst_sel     = dst;
    o_src_sel     = src;
    o_use_literal = use_lit;
    o_literal     = lit;
    repeat (hold) @(posedge i_ref_clk);
    #1;
    // released fields no longer show the old request
    o_op_valid    = 1'b0;
    o_op          = bla_pkg::bla_op_t'(~op);
    o_dst_sel     = ~dst;
    o_src_sel     = ~src;
    o_use_literal = ~use_lit;
    o_literal     = ~lit;
  endtask

  // operand bytes captured at port 00 and 01
  task automatic port_out(input logic [7:0] pid, input logic [7:0] d);
    if (pid == bla_pkg::MULT_PORT_LO) mul_a = d;
    else if (pid == bla_pkg::MULT_PORT_HI) mul_b = d;
  endtask

  // port 00 gives low product byte, 01 high
  function automatic logic [7:0] port_in(input logic [7:0] pid);
    return (pid == bla_pkg::MULT_PORT_HI) ? mul_prod[15:8] : mul_prod[7:0];
  endfunction
endmodule // bla_decoder_model

`default_nettype wire

/* verification/byte_logic_arith_alu_tb_top.sv */
// self-checking bench for the byte logic and add/subtract datapath
`default_nettype none
`timescale 1ns/1ns

module byte_logic_arith_alu_tb_top;
  typedef struct packed {
    bla_pkg::bla_op_t op;
    logic [3:0]       dst;
    logic [3:0]       src;
    logic             use_lit;
    logic [7:0]       lit;
    logic [7:0]       wr;
    logic             z;
    logic             c;
  } bla_row_t;

  logic                   i_ref_clk;
  logic                   i_rst;
  logic                   i_ce;
  logic [3:0]             i_peek_sel;
  logic                   op_valid;
  bla_pkg::bla_op_t       op;
  logic [3:0]             dst_sel;
  logic [3:0]             src_sel;
  logic                   use_literal;
  logic [7:0]             literal;
  logic                   o_busy;
  logic                   o_done;
  logic                   o_zero;
  logic                   o_carry;
  logic [7:0]             o_wr_data;
  logic [7:0]             o_peek_data;
  int                     n_fail;
  int                     checks;
  int                     n_done;
  int                     cyc;
  int                     snap;
  logic [7:0]             prod_lo;
  logic [7:0]             prod_hi;
  bla_row_t               rows [14];

  // ==========================================================
  // clock, design and partner
  initial i_ref_clk = 1'b0;
  always #25 i_ref_clk = ~i_ref_clk;

  bla_alu bla_alu_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_op_valid(op_valid), .i_op(op), .i_dst_sel(dst_sel),
    .i_src_sel(src_sel), .i_use_literal(use_literal),
    .i_literal(literal), .i_peek_sel(i_peek_sel), .o_busy(o_busy),
    .o_done(o_done), .o_zero(o_zero), .o_carry(o_carry),
    .o_wr_data(o_wr_data), .o_peek_data(o_peek_data)
  );

  bla_decoder_model bla_decoder_model_inst (
    .i_ref_clk(i_ref_clk), .o_op_valid(op_valid), .o_op(op),
    .o_dst_sel(dst_sel), .o_src_sel(src_sel),
    .o_use_literal(use_literal), .o_literal(literal)
  );

  // ==========================================================
  // checking helpers
  task automatic summarize();
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic cmp_bit(input logic g, e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic run_row(input bla_row_t r);
    i_peek_sel = r.dst;
    bla_decoder_model_inst.issue(r.op, r.dst, r.src, r.use_lit, r.lit, 1);
    cmp_bit(o_busy, 1'b1, "busy");
    tick(1);
    cmp_bit(o_done, 1'b1, "done");
    cmp_byte(o_wr_data, r.wr, "result");
    cmp_bit(o_zero, r.z, "zero flag");
    cmp_bit(o_carry, r.c, "carry flag");
    tick(1);
    cmp_bit(o_done, 1'b0, "done pulse");
    cmp_byte(o_peek_data, r.wr, "dest reg");
  endtask

  task automatic chk_reset();
    cmp_bit(o_busy, 1'b0, "busy reset");
    cmp_bit(o_done, 1'b0, "done reset");
    cmp_bit(o_zero, 1'b0, "zero reset");
    cmp_bit(o_carry, 1'b0, "carry reset");
    cmp_byte(o_wr_data, 8'h00, "wr reset");
    cmp_byte(o_peek_data, 8'h00, "reg reset");
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_done === 1'b1) n_done++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_peek_sel = 4'h5;
    rows[0]  = '{bla_pkg::OP_LOAD, 4'h1, 4'h0, 1'b1, 8'hF0, 8'hF0, 1'b0, 1'b0};
    rows[1]  = '{bla_pkg::OP_LOAD, 4'h2, 4'h0, 1'b1, 8'h3C, 8'h3C, 1'b0, 1'b0};
    rows[2]  = '{bla_pkg::OP_OR, 4'h1, 4'h2, 1'b0, 8'h00, 8'hFC, 1'b0, 1'b0};
    rows[3]  = '{bla_pkg::OP_AND, 4'h1, 4'h0, 1'b1, 8'h0F, 8'h0C, 1'b0, 1'b0};
    rows[4]  = '{bla_pkg::OP_ADD, 4'h1, 4'h0, 1'b1, 8'hF4, 8'h00, 1'b1, 1'b1};
    rows[5]  = '{bla_pkg::OP_LOAD, 4'h3, 4'h0, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1};
    rows[6]  = '{bla_pkg::OP_ADD_WITH_CARRY_IN, 4'h3, 4'h0, 1'b1, 8'hFF,
                 8'h00, 1'b1, 1'b1};
    rows[7]  = '{bla_pkg::OP_XOR, 4'h2, 4'h2, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0};
    rows[8]  = '{bla_pkg::OP_SUB, 4'h2, 4'h0, 1'b1, 8'h01, 8'hFF, 1'b0, 1'b1};
    rows[9]  = '{bla_pkg::OP_SUBTRACT_WITH_BORROW_IN, 4'h2, 4'h0, 1'b1, 8'hFE,
                 8'h00, 1'b1, 1'b0};
    rows[10] = '{bla_pkg::OP_LOAD, 4'hF, 4'h0, 1'b1, 8'h80, 8'h80, 1'b1, 1'b0};
    rows[11] = '{bla_pkg::OP_ADD, 4'hF, 4'hF, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1};
    rows[12] = '{bla_pkg::OP_LOAD, 4'hE, 4'h0, 1'b1, 8'hFF, 8'hFF, 1'b1, 1'b1};
    rows[13] = '{bla_pkg::OP_ADD, 4'hE, 4'h0, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0};
    tick(16);
    i_rst = 1'b0;
    tick(1);
    chk_reset();
    // in table order
    foreach (rows[i]) run_row(rows[i]);
    // second operand register left unchanged
    run_row('{bla_pkg::OP_LOAD, 4'h6, 4'h0, 1'b1, 8'h55, 8'h55, 1'b0, 1'b0});
    run_row('{bla_pkg::OP_LOAD, 4'h7, 4'h0, 1'b1, 8'hAA, 8'hAA, 1'b0, 1'b0});
    run_row('{bla_pkg::OP_XOR, 4'h6, 4'h7, 1'b0, 8'h00, 8'hFF, 1'b0, 1'b0});
    i_peek_sel = 4'h7;
    tick(2);
    cmp_byte(o_peek_data, 8'hAA, "source reg kept");
    // back to back 16-bit add, low byte then high byte
    run_row('{bla_pkg::OP_LOAD, 4'h8, 4'h0, 1'b1, 8'h9C, 8'h9C, 1'b0, 1'b0});
    run_row('{bla_pkg::OP_LOAD, 4'h9, 4'h0, 1'b1, 8'h12, 8'h12, 1'b0, 1'b0});
    bla_decoder_model_inst.issue(bla_pkg::OP_ADD, 4'h8, 4'h0, 1'b1, 8'h80, 1);
    tick(1);
    cmp_byte(o_wr_data, 8'h1C, "low byte sum");
    cmp_bit(o_carry, 1'b1, "low byte carry");
    bla_decoder_model_inst.issue(bla_pkg::OP_ADD_WITH_CARRY_IN, 4'h9, 4'h0,
                                 1'b1, 8'h01, 1);
    tick(1);
    cmp_bit(o_done, 1'b1, "second done");
    cmp_byte(o_wr_data, 8'h14, "high byte sum");
    cmp_bit(o_carry, 1'b0, "high byte carry");
    i_peek_sel = 4'h8;
    tick(2);
    cmp_byte(o_peek_data, 8'h1C, "low byte kept");
    // port-attached multiplier fed with the two sum bytes
    bla_decoder_model_inst.port_out(bla_pkg::MULT_PORT_LO, o_peek_data);
    bla_decoder_model_inst.port_out(bla_pkg::MULT_PORT_HI, o_wr_data);
    tick(1);
    prod_lo = bla_decoder_model_inst.port_in(bla_pkg::MULT_PORT_LO);
    prod_hi = bla_decoder_model_inst.port_in(bla_pkg::MULT_PORT_HI);
    cmp_byte(prod_lo, 8'h30, "product low byte");
    cmp_byte(prod_hi, 8'h02, "product high byte");
    // clock enable low takes nothing
    i_peek_sel = 4'h5;
    snap = n_done;
    i_ce = 1'b0;
    bla_decoder_model_inst.issue(bla_pkg::OP_ADD, 4'h5, 4'h0, 1'b1, 8'h01, 3);
    i_ce = 1'b1;
    tick(3);
    cmp_bit(n_done == snap, 1'b1, "frozen run");
    cmp_byte(o_peek_data, 8'h00, "frozen reg");
    // request held while busy runs once only
    bla_decoder_model_inst.issue(bla_pkg::OP_ADD, 4'h5, 4'h0, 1'b1, 8'h01, 2);
    tick(3);
    cmp_bit(n_done == snap + 1, 1'b1, "busy refusal");
    cmp_byte(o_peek_data, 8'h01, "single add");
    // reset in mid run, with an instruction in flight
    bla_decoder_model_inst.issue(bla_pkg::OP_ADD, 4'h5, 4'h0, 1'b1, 8'hFF, 1);
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
    tick(1);
    chk_reset();
    summarize();
  end
endmodule // byte_logic_arith_alu_tb_top

`default_nettype wire
